// ==== hdl/ias_pkg.sv ====
/*
  Shared definitions of the integer add/subtract unit: register map, field
  positions, reset values, operation codes and the issue/result carriers.
  Assumes one processor clock domain; no timescale here.
*/
package ias_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IAS_REG_CTRL = 8'h00;
  localparam logic [7:0] IAS_REG_EXC = 8'h04;
  localparam logic [7:0] IAS_REG_COND = 8'h08;
  localparam logic [7:0] IAS_REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] IAS_REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] IAS_REG_RES_LO = 8'h14;
  localparam logic [7:0] IAS_REG_RES_HI = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int IAS_CTRL_MODE64 = 0;
  localparam int IAS_EXC_WRAP = 0;
  localparam int IAS_EXC_RANGE = 1;
  localparam int IAS_EXC_STICKY = 2;
  localparam int IAS_COND_SUMMARY = 0;
  localparam int IAS_COND_EQ = 1;
  localparam int IAS_COND_GT = 2;
  localparam int IAS_COND_LT = 3;
  localparam int IAS_EV_RANGE = 0;
  localparam int IAS_EV_WRAP = 1;
  localparam int IAS_EV_W = 2;
  localparam logic IAS_MODE64_RST = 1'b1;
  localparam logic [IAS_EV_W-1:0] IAS_MASK_RST = 2'h0;
  localparam logic [15:0] IAS_SHIFT_FILL = 16'h0000;

  // ----------------------------------------------------------------------
  // Operations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    IAS_OP_ADDI,
    IAS_OP_ADDIS,
    IAS_OP_ADD,
    IAS_OP_SUBF,
    IAS_OP_ADDIC,
    IAS_OP_SUBFIC,
    IAS_OP_ADDC,
    IAS_OP_SUBFC
  } ias_op_t;

  typedef struct packed {
    ias_op_t op;
    logic rc;
    logic oe;
    logic first_src_is_r0;
    logic [4:0] dest;
    logic [63:0] first_src_gpr;
    logic [63:0] second_src_gpr;
    logic [15:0] signed_immediate;
  } ias_issue_t;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [63:0] data;
  } ias_result_t;

endpackage

// ==== hdl/ias_unit.sv ====
/*
  Integer add/subtract unit: plain, immediate, shifted-immediate, subtract-from
  and carrying forms, with record and overflow suffixes, a small register file
  on a plain strobe port and one level interrupt.
  Assumes issue inputs are synchronous to clk_sys and valid for one cycle.

  // How it works
  // (RL1) addi: sign-extended immediate plus source-or-zero
  // (RL2) addis: immediate shifted up sixteen, plus source-or-zero
  // (RL3) add: sum of both sources to destination
  // (RL4) dot suffix updates condition field, else unchanged
  // (RL5) o suffix updates range bit, else untouched
  // (RL6) subf: not first plus second plus one
  // (RL7) addic: immediate plus real source, wrap bit updated
  // (RL8) subfic: not first plus immediate plus one
  // (RL9) addc: sum of sources, wrap bit updated
  // (RL10) subfc: not first plus second plus one, wrap
  // (RL11) carrying o variants update wrap and range together
  // (RL12) wrap bit is carry out of 64 or 32
  // (RL13) record sets four condition bits, signed compare
  // (RL14) range bit is signed overflow; sticky set too
  // (RL15) immediate sign-extended to full width first
*/
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module ias_unit (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic iss_valid,
  input wire ias_pkg::ias_issue_t iss,
  output ias_pkg::ias_result_t res,
  output logic [3:0] first_condition_field,
  output logic [2:0] fixed_point_exception_register,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Subtract-from forms invert the first source and add one
  function automatic logic is_sub(input ias_pkg::ias_op_t op);
    return op == ias_pkg::IAS_OP_SUBF || op == ias_pkg::IAS_OP_SUBFIC ||
           op == ias_pkg::IAS_OP_SUBFC;
  endfunction

  function automatic logic is_carrying(input ias_pkg::ias_op_t op);
    return op == ias_pkg::IAS_OP_ADDIC || op == ias_pkg::IAS_OP_SUBFIC ||
           op == ias_pkg::IAS_OP_ADDC || op == ias_pkg::IAS_OP_SUBFC;
  endfunction

  // Only these forms have an encoding with the record suffix
  function automatic logic has_rc(input ias_pkg::ias_op_t op);
    return op == ias_pkg::IAS_OP_ADD || op == ias_pkg::IAS_OP_SUBF ||
           op == ias_pkg::IAS_OP_ADDIC || op == ias_pkg::IAS_OP_ADDC ||
           op == ias_pkg::IAS_OP_SUBFC;
  endfunction

  // Immediate forms carry no overflow-enable bit
  function automatic logic has_oe(input ias_pkg::ias_op_t op);
    return op == ias_pkg::IAS_OP_ADD || op == ias_pkg::IAS_OP_SUBF ||
           op == ias_pkg::IAS_OP_ADDC || op == ias_pkg::IAS_OP_SUBFC;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ias_pkg::ias_result_t res;
    logic [3:0] cond;
    logic wrap;
    logic range;
    logic sticky;
    logic mode64;
    logic [ias_pkg::IAS_EV_W-1:0] status;
    logic [ias_pkg::IAS_EV_W-1:0] mask;
    logic [31:0] rdata;
  } ias_state_t;

  ias_state_t st_r;
  ias_state_t st_nxt;

  logic [63:0] imm_ext;
  logic [63:0] opa;
  logic [63:0] opb;
  logic cin;
  logic [64:0] sum;
  logic [32:0] sum_lo;
  logic carry_out;
  logic ovf;
  logic rc_eff;
  logic oe_eff;
  logic [63:0] cmp_val;
  logic [ias_pkg::IAS_EV_W-1:0] ev;
  logic wr_exc;

  // ----------------------------------------------------------------------
  // Operand selection and adder
  // ----------------------------------------------------------------------
  // Immediate widened before any use so negative offsets subtract
  assign imm_ext = {{48{iss.signed_immediate[15]}}, iss.signed_immediate}; // RL15

  // First operand: register zero reads as zero only for addi/addis
  always_comb begin
    unique case (iss.op)
      ias_pkg::IAS_OP_ADDI,
      ias_pkg::IAS_OP_ADDIS: begin
        opa = iss.first_src_is_r0 ? 64'h0 : iss.first_src_gpr; // RL1 RL2
      end
      ias_pkg::IAS_OP_SUBF,
      ias_pkg::IAS_OP_SUBFIC,
      ias_pkg::IAS_OP_SUBFC: begin
        opa = ~iss.first_src_gpr; // RL6 RL8 RL10
      end
      ias_pkg::IAS_OP_ADD,
      ias_pkg::IAS_OP_ADDIC,
      ias_pkg::IAS_OP_ADDC: begin
        opa = iss.first_src_gpr; // RL3 RL7 RL9
      end
    endcase
  end

  // Second operand: immediate, shifted immediate or second register
  always_comb begin
    unique case (iss.op)
      ias_pkg::IAS_OP_ADDI,
      ias_pkg::IAS_OP_ADDIC,
      ias_pkg::IAS_OP_SUBFIC: begin
        opb = imm_ext; // RL1 RL7 RL8
      end
      ias_pkg::IAS_OP_ADDIS: begin
        opb = {imm_ext[47:0], ias_pkg::IAS_SHIFT_FILL}; // RL2
      end
      ias_pkg::IAS_OP_ADD,
      ias_pkg::IAS_OP_SUBF,
      ias_pkg::IAS_OP_ADDC,
      ias_pkg::IAS_OP_SUBFC: begin
        opb = iss.second_src_gpr; // RL3 RL6 RL9 RL10
      end
    endcase
  end

  // One shared adder; the low-half sum gives the 32-bit mode carry
  assign cin = is_sub(iss.op); // RL6 RL8 RL10
  assign sum = {1'b0, opa} + {1'b0, opb} + {64'h0, cin};
  assign sum_lo = {1'b0, opa[31:0]} + {1'b0, opb[31:0]} + {32'h0, cin};
  assign carry_out = st_r.mode64 ? sum[64] : sum_lo[32]; // RL12

  // Signed overflow: like-signed operands giving an unlike-signed result
  assign ovf = st_r.mode64 ?
               (opa[63] == opb[63]) && (sum[63] != opa[63]) :
               (opa[31] == opb[31]) && (sum_lo[31] != opa[31]); // RL14

  assign rc_eff = iss_valid && iss.rc && has_rc(iss.op); // RL4
  assign oe_eff = iss_valid && iss.oe && has_oe(iss.op); // RL5

  // Compare value: low word sign-extended in 32-bit mode
  assign cmp_val = st_r.mode64 ? sum[63:0] : {{32{sum_lo[31]}}, sum_lo[31:0]}; // RL13

  assign ev[ias_pkg::IAS_EV_RANGE] = oe_eff && ovf;
  assign ev[ias_pkg::IAS_EV_WRAP] = iss_valid && is_carrying(iss.op) && carry_out;
  assign wr_exc = bus_wr && bus_addr == ias_pkg::IAS_REG_EXC;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Bus writes land first; a same-cycle instruction overrides the bits it
  // owns, so software never silently undoes an architectural update.
  always_comb begin
    st_nxt = st_r;
    st_nxt.res.valid = iss_valid;
    st_nxt.rdata = 32'h0;
    if (bus_wr) begin
      unique case (bus_addr)
        ias_pkg::IAS_REG_CTRL: begin
          st_nxt.mode64 = bus_wdata[ias_pkg::IAS_CTRL_MODE64];
        end
        ias_pkg::IAS_REG_EXC: begin
          st_nxt.wrap = bus_wdata[ias_pkg::IAS_EXC_WRAP];
          st_nxt.range = bus_wdata[ias_pkg::IAS_EXC_RANGE];
          st_nxt.sticky = bus_wdata[ias_pkg::IAS_EXC_STICKY];
        end
        ias_pkg::IAS_REG_IRQ_MASK: begin
          st_nxt.mask = bus_wdata[ias_pkg::IAS_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (iss_valid) begin
      st_nxt.res.dest = iss.dest;
      st_nxt.res.data = sum[63:0]; // RL3
      if (is_carrying(iss.op)) begin
        st_nxt.wrap = carry_out; // RL9 RL12
      end
      if (oe_eff) begin
        st_nxt.range = ovf; // RL11 RL14
        st_nxt.sticky = st_nxt.sticky | ovf; // RL14
      end
      if (rc_eff) begin
        st_nxt.cond[ias_pkg::IAS_COND_LT] = cmp_val[63]; // RL13
        st_nxt.cond[ias_pkg::IAS_COND_GT] = !cmp_val[63] && cmp_val != 64'h0;
        st_nxt.cond[ias_pkg::IAS_COND_EQ] = cmp_val == 64'h0;
        st_nxt.cond[ias_pkg::IAS_COND_SUMMARY] = st_nxt.sticky;
      end
    end
    // Read clears status; a new event in the same cycle still sets
    if (bus_rd) begin
      unique case (bus_addr)
        ias_pkg::IAS_REG_CTRL: begin
          st_nxt.rdata = {31'h0, st_r.mode64};
        end
        ias_pkg::IAS_REG_EXC: begin
          st_nxt.rdata = {29'h0, st_r.sticky, st_r.range, st_r.wrap};
        end
        ias_pkg::IAS_REG_COND: begin
          st_nxt.rdata = {28'h0, st_r.cond};
        end
        ias_pkg::IAS_REG_IRQ_STATUS: begin
          st_nxt.rdata = {30'h0, st_r.status};
          st_nxt.status = '0;
        end
        ias_pkg::IAS_REG_IRQ_MASK: begin
          st_nxt.rdata = {30'h0, st_r.mask};
        end
        ias_pkg::IAS_REG_RES_LO: begin
          st_nxt.rdata = st_r.res.data[31:0];
        end
        ias_pkg::IAS_REG_RES_HI: begin
          st_nxt.rdata = st_r.res.data[63:32];
        end
        default: begin
          st_nxt.rdata = 32'h0;
        end
      endcase
    end
    st_nxt.status = st_nxt.status | ev;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.mode64 <= ias_pkg::IAS_MODE64_RST;
      st_r.mask <= ias_pkg::IAS_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign res = st_r.res;
  assign first_condition_field = st_r.cond;
  assign fixed_point_exception_register = {st_r.sticky, st_r.range, st_r.wrap};
  assign bus_rdata = st_r.rdata;
  assign irq = |(st_r.status & st_r.mask);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_ADDI_ZERO: assert property ( // RL1
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDI && iss.first_src_is_r0
    |=> res.valid && res.data == $past(imm_ext))
    else $error("addi with register zero did not yield the immediate");

  AST_ADDIS_SUM: assert property ( // RL2
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDIS && !iss.first_src_is_r0
    |=> res.data == $past(iss.first_src_gpr + {imm_ext[47:0], 16'h0000}))
    else $error("addis result wrong");

  AST_ADD_SUM: assert property ( // RL3
    iss_valid && iss.op == ias_pkg::IAS_OP_ADD
    |=> res.data == $past(iss.first_src_gpr + iss.second_src_gpr))
    else $error("add result wrong");

  AST_COND_HOLD: assert property ( // RL4
    iss_valid && !iss.rc |=> $stable(first_condition_field))
    else $error("condition field changed without record suffix");

  AST_RANGE_HOLD: assert property ( // RL5
    iss_valid && !iss.oe && !wr_exc
    |=> fixed_point_exception_register[1] == $past(st_r.range))
    else $error("range bit changed without overflow suffix");

  AST_SUBF_DIFF: assert property ( // RL6
    iss_valid && iss.op == ias_pkg::IAS_OP_SUBF
    |=> res.data == $past(iss.second_src_gpr - iss.first_src_gpr))
    else $error("subf result wrong");

  AST_ADDIC_NO_ZERO: assert property ( // RL7
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDIC && iss.first_src_is_r0
    |=> res.data == $past(iss.first_src_gpr + imm_ext))
    else $error("addic substituted zero for the source");

  AST_SUBFIC_DIFF: assert property ( // RL8
    iss_valid && iss.op == ias_pkg::IAS_OP_SUBFIC
    |=> res.data == $past(imm_ext - iss.first_src_gpr))
    else $error("subfic result wrong");

  AST_WRAP64: assert property ( // RL12
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDC && st_r.mode64
    |=> fixed_point_exception_register[0] ==
        $past(({1'b0, iss.first_src_gpr} + {1'b0, iss.second_src_gpr}) >> 64))
    else $error("wrap bit is not the 64-bit carry out");

  AST_COND_EQ: assert property ( // RL13
    iss_valid && iss.rc && iss.op == ias_pkg::IAS_OP_ADD && st_r.mode64
    |=> first_condition_field[1] == (res.data == 64'h0))
    else $error("equal bit does not match a zero result");

  AST_STICKY_SET: assert property ( // RL14
    oe_eff && ovf
    |=> fixed_point_exception_register[2] && (irq || !st_r.mask[ias_pkg::IAS_EV_RANGE]))
    else $error("sticky bit not set after overflow");

  AST_ADDC_SUM: assert property ( // RL9
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDC
    |=> res.data == $past(iss.first_src_gpr + iss.second_src_gpr))
    else $error("addc result wrong");

  AST_SUBFC_DIFF: assert property ( // RL10
    iss_valid && iss.op == ias_pkg::IAS_OP_SUBFC
    |=> res.data == $past(iss.second_src_gpr - iss.first_src_gpr))
    else $error("subfc result wrong");

  // 32-bit mode takes the carry out of the low word, not the full sum
  AST_WRAP32: assert property ( // RL12
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDC && !st_r.mode64
    |=> fixed_point_exception_register[0] ==
        $past(({1'b0, iss.first_src_gpr[31:0]} + {1'b0, iss.second_src_gpr[31:0]}) >> 32))
    else $error("wrap bit is not the 32-bit carry out");

  AST_IMM_SEXT: assert property ( // RL15
    iss_valid && iss.op == ias_pkg::IAS_OP_ADDIC
    |=> res.data ==
        $past(iss.first_src_gpr + {{48{iss.signed_immediate[15]}}, iss.signed_immediate}))
    else $error("immediate was not sign-extended");

  AST_COND_LT32: assert property ( // RL13
    iss_valid && iss.rc && iss.op == ias_pkg::IAS_OP_ADD && !st_r.mode64
    |=> first_condition_field[3] == res.data[31])
    else $error("32-bit mode less-than bit does not follow the low word sign");

endmodule

// ==== sim/ias_gpr_model.sv ====
/*
  Write-back register file model standing beyond the unit's result port.
  Assumes results arrive as one-cycle ias_result_t pulses on clk_sys.
*/
`timescale 1ns/1ns
module ias_gpr_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ias_pkg::ias_result_t res,
  input wire logic [4:0] rd_idx,
  output logic [63:0] rd_val
);
  logic [63:0] gpr_r [32];

  // Unwritten entries hold a marker, so a lost write-back cannot pass as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        gpr_r[i] <= 64'ha5a5_a5a5_a5a5_a5a5;
      end
    end else if (res.valid) begin
      gpr_r[res.dest] <= res.data;
    end
  end

  assign rd_val = gpr_r[rd_idx];
endmodule

// ==== sim/testbench.sv ====
/*
  Self-checking bench of the add/subtract unit: issue driver with a reference
  model, register port driver, and a monitor that pops expected notes.
  Assumes the one-cycle answer latencies of the unit's issue and register ports.
*/
`timescale 1ns/1ns
module testbench;
  typedef struct packed {
    logic [4:0] dest;
    logic [63:0] data;
    logic [3:0] cond;
    logic [2:0] exc;
  } ias_tb_exp_t;
  logic clk_sys, rst_n, iss_valid, bus_wr, bus_rd, irq, rd_flag, mode64_m;
  ias_pkg::ias_issue_t iss;
  ias_pkg::ias_result_t res;
  logic [3:0] first_condition_field, cond_m;
  logic [2:0] fixed_point_exception_register, exc_m;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, seed;
  logic [4:0] rd_idx;
  logic [63:0] rd_val, last_r;
  logic [1:0] stat_m;
  int fails, n_compared;
  ias_tb_exp_t exp_q[$], e_mon;
  logic [31:0] rd_q[$];

  ias_unit u_ias_unit (.clk_sys(clk_sys), .rst_n(rst_n), .iss_valid(iss_valid), .iss(iss),
    .res(res), .first_condition_field(first_condition_field),
    .fixed_point_exception_register(fixed_point_exception_register), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));
  ias_gpr_model u_ias_gpr_model (.clk_sys(clk_sys), .rst_n(rst_n), .res(res), .rd_idx(rd_idx),
    .rd_val(rd_val));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Op codes by enum order: 0 addi 1 addis 2 add 3 subf 4 addic 5 subfic 6 addc 7 subfc
  task automatic issue(input logic [2:0] k, input logic rc, input logic oe, input logic r0,
                       input logic [63:0] a, input logic [63:0] b, input logic [15:0] imm,
                       input logic [4:0] d);
    logic [63:0] se, x, y, rv;
    logic [64:0] s;
    logic [32:0] s32;
    logic sub, car, ov;
    se = {{48{imm[15]}}, imm};
    sub = k inside {3, 5, 7};
    x = sub ? ~a : ((r0 && k < 2) ? 64'h0 : a);
    y = (k inside {2, 3, 6, 7}) ? b : ((k == 1) ? {se[47:0], 16'h0000} : se);
    s = {1'b0, x} + {1'b0, y} + {64'h0, sub};
    s32 = {1'b0, x[31:0]} + {1'b0, y[31:0]} + {32'h0, sub};
    last_r = s[63:0];
    car = mode64_m ? s[64] : s32[32];
    ov = mode64_m ? (x[63] == y[63] && last_r[63] != x[63])
                  : (x[31] == y[31] && last_r[31] != x[31]);
    // Carrying forms update the wrap bit; o forms the range and sticky bits
    if (k >= 4) begin
      exc_m[0] = car;
      stat_m[1] = stat_m[1] | car;
    end
    if (oe && k inside {2, 3, 6, 7}) begin
      exc_m[1] = ov;
      exc_m[2] = exc_m[2] | ov;
      stat_m[0] = stat_m[0] | ov;
    end
    if (rc && !(k inside {0, 1, 5})) begin
      rv = mode64_m ? last_r : {{32{last_r[31]}}, last_r[31:0]};
      cond_m = {rv[63], !rv[63] && rv != 64'h0, rv == 64'h0, exc_m[2]};
    end
    exp_q.push_back('{d, last_r, cond_m, exc_m});
    @(posedge clk_sys);
    iss_valid <= 1'b1;
    iss <= '{op: ias_pkg::ias_op_t'(k), rc: rc, oe: oe, first_src_is_r0: r0, dest: d,
             first_src_gpr: a, second_src_gpr: b, signed_immediate: imm};
  endtask

  task automatic bus_op(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr <= wr;
    bus_rd <= !wr;
    bus_addr <= ad;
    bus_wdata <= d;
    if (!wr) rd_q.push_back(d);
  endtask

  task automatic idle();
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    iss_valid <= 1'b0;
  endtask

  // Monitor at the falling edge, where every output of the last edge has settled
  always @(negedge clk_sys) begin
    if (rst_n && res.valid === 1'b1) begin
      e_mon = exp_q.pop_front();
      check(res.dest, e_mon.dest);
      check(res.data, e_mon.data);
      check(first_condition_field, e_mon.cond);
      check(fixed_point_exception_register, e_mon.exc);
    end
    if (rd_flag) check(bus_rdata, rd_q.pop_front());
    rd_flag = bus_rd;
  end

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {rst_n, iss_valid, bus_wr, bus_rd, rd_flag, iss, bus_addr, bus_wdata, rd_idx} = '0;
    {exc_m, cond_m, stat_m, last_r} = '0;
    mode64_m = 1'b1;
    seed = 32'h65ab1904;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus_op(1'b0, ias_pkg::IAS_REG_CTRL, 32'h1);
    bus_op(1'b0, ias_pkg::IAS_REG_IRQ_MASK, 32'h0);
    bus_op(1'b1, ias_pkg::IAS_REG_COND, 32'hf);
    bus_op(1'b0, ias_pkg::IAS_REG_COND, 32'h0);
    bus_op(1'b0, 8'h1c, 32'h0);
    bus_op(1'b1, ias_pkg::IAS_REG_EXC, 32'h5);
    bus_op(1'b0, ias_pkg::IAS_REG_EXC, 32'h5);
    exc_m = 3'h5;
    idle();
    $display("test registers done");
    // Boundaries: r0 substitution, negative shifted immediate, overflow, carries
    issue(3'd0, 1'b1, 1'b1, 1'b1, 64'h1234, 64'h0, 16'hfffe, 5'd1);
    issue(3'd1, 1'b0, 1'b0, 1'b0, 64'h10, 64'h0, 16'h8000, 5'd2);
    issue(3'd2, 1'b1, 1'b1, 1'b0, 64'h7fff_ffff_ffff_ffff, 64'h1, 16'h0, 5'd3);
    issue(3'd6, 1'b1, 1'b1, 1'b0, 64'hffff_ffff_ffff_ffff, 64'h1, 16'h0, 5'd4);
    issue(3'd7, 1'b1, 1'b0, 1'b0, 64'h5, 64'h5, 16'h0, 5'd5);
    issue(3'd5, 1'b1, 1'b1, 1'b0, 64'h3, 64'h0, 16'h0003, 5'd6);
    issue(3'd4, 1'b1, 1'b1, 1'b1, 64'h1, 64'h0, 16'hffff, 5'd7);
    idle();
    bus_op(1'b0, ias_pkg::IAS_REG_RES_HI, last_r[63:32]);
    bus_op(1'b1, ias_pkg::IAS_REG_IRQ_MASK, 32'h3);
    idle();
    @(negedge clk_sys);
    check(irq, 1'b1);
    bus_op(1'b0, ias_pkg::IAS_REG_IRQ_STATUS, {30'h0, stat_m});
    stat_m = 2'h0;
    idle();
    @(negedge clk_sys);
    check(irq, 1'b0);
    bus_op(1'b1, ias_pkg::IAS_REG_IRQ_MASK, 32'h1);
    idle();
    issue(3'd6, 1'b0, 1'b0, 1'b0, 64'hffff_ffff_ffff_ffff, 64'h2, 16'h0, 5'd8);
    idle();
    @(negedge clk_sys);
    check(irq, 1'b0);
    bus_op(1'b0, ias_pkg::IAS_REG_IRQ_STATUS, {30'h0, stat_m});
    stat_m = 2'h0;
    // Drop the read strobe, or the status would be read again under the next issues
    idle();
    $display("test boundaries and interrupt done");
    // Every op, suffix pair and both modes, back to back with random operands
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 64; i++) begin
        issue(i[2:0], i[3], i[4], 1'(xs()), {xs(), xs()}, {xs(), xs()}, 16'(xs()), 5'(i));
      end
      idle();
      bus_op(1'b0, ias_pkg::IAS_REG_RES_LO, last_r[31:0]);
      bus_op(1'b0, ias_pkg::IAS_REG_IRQ_STATUS, {30'h0, stat_m});
      stat_m = 2'h0;
      bus_op(1'b1, ias_pkg::IAS_REG_CTRL, 32'h0);
      mode64_m = 1'b0;
      idle();
      issue(3'd2, 1'b1, 1'b1, 1'b0, 64'h7fff_ffff, 64'h1, 16'h0, 5'd9);
      issue(3'd6, 1'b1, 1'b0, 1'b0, 64'hffff_ffff, 64'h1, 16'h0, 5'd9);
      idle();
      $display("test random pass %0d done", m);
    end
    rd_idx <= 5'd9;
    for (int t = 0; t < 20 && (exp_q.size() != 0 || rd_q.size() != 0); t++) begin
      @(posedge clk_sys);
    end
    if (exp_q.size() != 0 || rd_q.size() != 0) begin
      fails++;
      $display("Error at %0t: results missing", $time);
    end
    // The model's write-back lands in this edge's update, so look half a cycle later
    @(negedge clk_sys);
    check(rd_val, last_r);
    results();
  end
endmodule
